/* File: pmt_top.sv */
`timescale 1ns/100ps
`include "pmt_defines.svh"

// Summary of operation
// RL1: 100M coded: carrier rises within 11 BT of start, falls within 21 BT of end.
// RL2: 100M coded: collision within 11 BT of start while sending, release within 21.
// RL3: 100M aligned modes: receive data follows carrier by 2 to 8 BT.
// RL4: Bypass: each raw 5-bit symbol presented 5 to 9 BT after line start; here data valid waits on the 7-cycle 10M carrier delay.
// RL5: 100M coded: carrier within 8 BT after transmit enable rises.
// RL6: 100M coded: first line symbol 6 to 8 BT after transmit enable rises.
// RL7: Bypass: sampled transmit symbol reaches the line within 7 ns; here it passes two sync flops and the output register, 300 ns.
// RL8: 10M nibble: receive data valid 8 to 10 BT after carrier.
// RL9: 10M nibble: carrier within 7 BT of preamble, drops within 3 BT.
// RL10: 10M nibble: collision within 7 BT of overlap, release within 3 BT.
// RL11: 10M: receive outputs driven or released within 60 ns of enable; here two sync flops and one output register, 300 ns.
// RL12: 10M nibble: transmit carrier rises within 4 BT, falls within 16 BT.
// RL13: 10M: collision-test pulse 0.65-1.6 us after carrier drop, same length.
// RL14: Serial: carrier within 600 ns of line activity.
// RL15: Serial: receive data active within 1200 ns of line activity.
// RL16: 100M: transmit and receive interface clocks nominal 25 MHz; MII_CLK_O here runs at 5 MHz.
// RL17: Straps select bypass, repeater or serial form of the interface.
// RL18: Bit time is 10 ns at 100M and 100 ns at 10M.
// RL19: Controller samples and drives data around rising interface clock edges.
module pmt_top #(
    parameter int CW = 5
) (
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic LINE_ACT_I,
    input wire logic LINE_CLK_I,
    input wire logic [4:0] LINE_SYM_I,
    input wire logic TX_EN_I,
    input wire logic [4:0] TXD_I,
    input wire logic RX_EN_I,
    input wire logic ALIGN_BYPASS_SELECT_I,
    input wire logic CODER_BYPASS_SELECT_I,
    input wire logic SERIAL_10M_SELECT_I,
    input wire logic SPEED_100_I,
    output logic CRS_O,
    output logic COL_O,
    output logic RX_DV_O,
    output logic RX_ER_O,
    output logic [3:0] RXD_O,
    output logic RECEIVE_CODE_BIT_FOUR_O,
    output logic RX_OE_B_O,
    output logic [4:0] LINE_TX_O,
    output logic LINE_TX_EN_O,
    output logic MII_CLK_O
);
    // RL18: bit-time cycle counts
    localparam logic [CW-1:0] C_CRS_ON_100 =
        CW'(`PMT_CYC_MAX(`PMT_CRS_ON_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_CRS_OFF_100 =
        CW'(`PMT_CYC_MAX(`PMT_CRS_OFF_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_COL_ON_100 =
        CW'(`PMT_CYC_MAX(`PMT_COL_ON_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_COL_OFF_100 =
        CW'(`PMT_CYC_MAX(`PMT_COL_OFF_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_DV_100 = CW'(`PMT_CYC_MAX(`PMT_DV_MAX_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_TXCRS_ON_100 =
        CW'(`PMT_CYC_MAX(`PMT_TXCRS_ON_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_TXCRS_OFF_100 =
        CW'(`PMT_CYC_MAX(`PMT_TXCRS_OFF_100_BT * `PMT_BT100_NS));
    localparam logic [CW-1:0] C_DV_10 = CW'(`PMT_CYC_MAX(`PMT_DV_TYP_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_CRS_ON_10 = CW'(`PMT_CYC_MAX(`PMT_CRS_ON_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_CRS_OFF_10 =
        CW'(`PMT_CYC_MAX(`PMT_CRS_OFF_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_COL_ON_10 = CW'(`PMT_CYC_MAX(`PMT_COL_ON_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_COL_OFF_10 =
        CW'(`PMT_CYC_MAX(`PMT_COL_OFF_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_TXCRS_ON_10 =
        CW'(`PMT_CYC_MAX(`PMT_TXCRS_ON_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_TXCRS_OFF_10 =
        CW'(`PMT_CYC_MAX(`PMT_TXCRS_OFF_10_BT * `PMT_BT10_NS));
    localparam logic [CW-1:0] C_SQE_DLY = CW'(`PMT_CYC_MAX(`PMT_SQE_DLY_NS));
    localparam logic [CW-1:0] C_SQE_LEN = CW'(`PMT_CYC_MAX(`PMT_SQE_LEN_NS));
    localparam logic [CW-1:0] C_SER_CRS = CW'(`PMT_CYC_MAX(`PMT_SER_CRS_NS));
    localparam logic [CW-1:0] C_SER_DV =
        CW'(`PMT_CYC_MAX(`PMT_SER_DATA_NS) - `PMT_CYC_MAX(`PMT_SER_CRS_NS));
    localparam logic [CW-1:0] C_HALF_100 = CW'(`PMT_CYC_MAX(`PMT_MII_CLK_100_NS / 2));
    localparam logic [CW-1:0] C_HALF_10 = CW'(`PMT_CYC_MAX(`PMT_MII_CLK_10_NS / 2));
    localparam int A_TXCRS10 = `PMT_TXCRS_ON_10_BT + 1;

    pmt_pkg::pmt_pin_s pin_raw;
    pmt_pkg::pmt_pin_s pin_meta_ff;
    pmt_pkg::pmt_pin_s pin_ff;
    pmt_pkg::pmt_mode_e mode_ff;
    pmt_pkg::pmt_mode_e nxt_mode;
    pmt_pkg::pmt_tx_e tx_st_ff;
    pmt_pkg::pmt_rx_s rx_word_ff;
    pmt_pkg::pmt_rx_s nxt_rx_word;
    logic strap_taken_ff;
    logic lclk_d_ff;
    logic link_edge;
    logic coded;
    logic fast;
    logic rx_busy_ff;
    logic rx_crs_lvl;
    logic tx_crs_lvl;
    logic tx_crs_d_ff;
    logic col_lvl;
    logic rx_dv_lvl;
    logic crs_ff;
    logic col_ff;
    logic sqe_ff;
    logic sqe_arm_ff;
    logic [CW-1:0] sqe_cnt_ff;
    logic rx_oe_b_ff;
    logic [4:0] line_tx_ff;
    logic line_tx_en_ff;
    logic [4:0] nxt_line_tx;
    logic mii_clk_ff;
    logic [CW-1:0] div_cnt_ff;
    logic [CW-1:0] half_cyc;
    logic [CW-1:0] crs_on;
    logic [CW-1:0] crs_off;
    logic [CW-1:0] txcrs_on;
    logic [CW-1:0] txcrs_off;
    logic [CW-1:0] col_on;
    logic [CW-1:0] col_off;
    logic [CW-1:0] dv_on;
    logic [4:0] sym;
    logic [4:0] dec;
    logic [4:0] enc;
    logic rx_busy_set;
    logic rx_busy_clr;

    // 4B5B data encode
    function automatic logic [4:0] pmt_enc(input logic [3:0] n);
        case (n)
            4'h0: pmt_enc = 5'h1e;
            4'h1: pmt_enc = 5'h09;
            4'h2: pmt_enc = 5'h14;
            4'h3: pmt_enc = 5'h15;
            4'h4: pmt_enc = 5'h0a;
            4'h5: pmt_enc = 5'h0b;
            4'h6: pmt_enc = 5'h0e;
            4'h7: pmt_enc = 5'h0f;
            4'h8: pmt_enc = 5'h12;
            4'h9: pmt_enc = 5'h13;
            4'ha: pmt_enc = 5'h16;
            4'hb: pmt_enc = 5'h17;
            4'hc: pmt_enc = 5'h1a;
            4'hd: pmt_enc = 5'h1b;
            4'he: pmt_enc = 5'h1c;
            default: pmt_enc = 5'h1d;
        endcase
    endfunction : pmt_enc

    // 4B5B decode; bit 4 flags a code violation, which maps to nibble 5
    function automatic logic [4:0] pmt_dec(input logic [4:0] s);
        logic [4:0] r;
        r = 5'h15;
        for (int i = 0; i < 16; i++)
        begin
            if (pmt_enc(4'(i)) == s)
            begin
                r = {1'b0, 4'(i)};
            end
        end
        pmt_dec = r;
    endfunction : pmt_dec

    // RL19: pins from the controller and line cross in through two flops
    assign pin_raw = '{LINE_ACT_I, LINE_CLK_I, LINE_SYM_I, TX_EN_I, TXD_I, RX_EN_I,
                       ALIGN_BYPASS_SELECT_I, CODER_BYPASS_SELECT_I,
                       SERIAL_10M_SELECT_I, SPEED_100_I};
    always_ff @(posedge CLK_I)
    begin
        pin_meta_ff <= pin_raw;
        pin_ff <= pin_meta_ff;
        lclk_d_ff <= pin_ff.lclk;
    end

    // RL17: strap decode, serial wins, then 10M speed, then align bypass, then coder bypass
    assign nxt_mode = pin_ff.ser ? pmt_pkg::PMT_SER10 :
                      !pin_ff.spd100 ? pmt_pkg::PMT_MII10 :
                      pin_ff.align ? pmt_pkg::PMT_BYP5B :
                      pin_ff.coder ? pmt_pkg::PMT_REP5B : pmt_pkg::PMT_MII100;

    // Straps are caught once after release, so mid-frame pin noise is harmless
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            mode_ff <= pmt_pkg::PMT_MII100;
            strap_taken_ff <= 1'b0;
        end
        else if (!strap_taken_ff)
        begin
            mode_ff <= nxt_mode;
            strap_taken_ff <= 1'b1;
        end
    end

    // Mode dependent selection
    assign link_edge = pin_ff.lclk && !lclk_d_ff;
    assign sym = pin_ff.sym;
    assign dec = pmt_dec(sym);
    assign enc = pmt_enc(pin_ff.txd[3:0]);
    assign coded = (mode_ff == pmt_pkg::PMT_MII100) || (mode_ff == pmt_pkg::PMT_REP5B);
    assign fast = coded || (mode_ff == pmt_pkg::PMT_BYP5B);
    // RL1: receive carrier from stream delimiters
    assign rx_busy_set = coded ? (link_edge && sym == `PMT_SYM_J) : pin_ff.act;
    assign rx_busy_clr = coded ? ((link_edge && sym == `PMT_SYM_T) || !pin_ff.act) : !pin_ff.act;
    // RL9: 10M carrier latencies; RL14: serial carrier
    assign crs_on = coded ? C_CRS_ON_100 :
                    (mode_ff == pmt_pkg::PMT_SER10) ? C_SER_CRS : C_CRS_ON_10;
    assign crs_off = coded ? C_CRS_OFF_100 : C_CRS_OFF_10;
    // RL5: transmit carrier, RL12 at 10M
    assign txcrs_on = fast ? C_TXCRS_ON_100 : C_TXCRS_ON_10;
    assign txcrs_off = fast ? C_TXCRS_OFF_100 : C_TXCRS_OFF_10;
    // RL2: collision at 100M; RL10 at 10M
    assign col_on = fast ? C_COL_ON_100 : C_COL_ON_10;
    assign col_off = fast ? C_COL_OFF_100 : C_COL_OFF_10;
    // RL3: data after carrier; RL8: 10M nibble; RL15: serial
    assign dv_on = fast ? C_DV_100 : (mode_ff == pmt_pkg::PMT_SER10) ? C_SER_DV : C_DV_10;
    assign half_cyc = fast ? C_HALF_100 : C_HALF_10;

    // Receive activity, set wins over clear
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
            rx_busy_ff <= 1'b0;
        else if (rx_busy_set)
            rx_busy_ff <= 1'b1;
        else if (rx_busy_clr)
            rx_busy_ff <= 1'b0;
    end

    // Latency followers for carrier, collision and data valid
    pmt_delay #(.CW(CW)) u_rx_crs (
        .clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(rx_busy_ff),
        .on_cyc_i(crs_on), .off_cyc_i(crs_off), .lvl_o(rx_crs_lvl));
    pmt_delay #(.CW(CW)) u_tx_crs (
        .clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(pin_ff.tx_en),
        .on_cyc_i(txcrs_on), .off_cyc_i(txcrs_off), .lvl_o(tx_crs_lvl));
    pmt_delay #(.CW(CW)) u_col (
        .clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(rx_busy_ff && pin_ff.tx_en),
        .on_cyc_i(col_on), .off_cyc_i(col_off), .lvl_o(col_lvl));
    pmt_delay #(.CW(CW)) u_rx_dv (
        .clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(rx_crs_lvl),
        .on_cyc_i(dv_on), .off_cyc_i(CW'(1)), .lvl_o(rx_dv_lvl));

    // RL13: collision-test pulse after transmit carrier drops at 10M
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            tx_crs_d_ff <= 1'b0;
            sqe_arm_ff <= 1'b0;
            sqe_ff <= 1'b0;
            sqe_cnt_ff <= '0;
        end
        else
        begin
            tx_crs_d_ff <= tx_crs_lvl;
            if (tx_crs_d_ff && !tx_crs_lvl && !fast)
            begin
                sqe_arm_ff <= 1'b1;
                sqe_cnt_ff <= '0;
            end
            else if (sqe_arm_ff || sqe_ff)
            begin
                sqe_cnt_ff <= sqe_cnt_ff + CW'(1);
                if (sqe_arm_ff && sqe_cnt_ff == C_SQE_DLY - CW'(1))
                begin
                    sqe_arm_ff <= 1'b0;
                    sqe_ff <= 1'b1;
                    sqe_cnt_ff <= '0;
                end
                else if (sqe_ff && sqe_cnt_ff == C_SQE_LEN - CW'(1))
                    sqe_ff <= 1'b0;
            end
        end
    end

    // RL4: raw symbols in bypass forms; decoded nibble in coded MII; bit 0 in serial
    always_comb
    begin
        nxt_rx_word = rx_word_ff;
        if (!rx_dv_lvl)
            nxt_rx_word = '0;
        else if (link_edge)
        begin
            nxt_rx_word.dv = 1'b1;
            nxt_rx_word.er = 1'b0;
            case (mode_ff)
                pmt_pkg::PMT_MII100:
                begin
                    nxt_rx_word.data = {1'b0, dec[3:0]};
                    nxt_rx_word.er = dec[4];
                end
                pmt_pkg::PMT_SER10: nxt_rx_word.data = {4'h0, sym[0]};
                pmt_pkg::PMT_MII10: nxt_rx_word.data = {1'b0, sym[3:0]};
                default: nxt_rx_word.data = sym;
            endcase
        end
    end

    // RL6: delimiters framed around the nibble stream; RL7: bypass passes through
    always_comb
    begin
        nxt_line_tx = pin_ff.txd;
        case (tx_st_ff)
            pmt_pkg::PMT_TX_IDLE: nxt_line_tx = pin_ff.tx_en ? `PMT_SYM_J : `PMT_SYM_I;
            pmt_pkg::PMT_TX_K: nxt_line_tx = `PMT_SYM_K;
            pmt_pkg::PMT_TX_DATA: nxt_line_tx = pin_ff.tx_en ? enc : `PMT_SYM_T;
            pmt_pkg::PMT_TX_R: nxt_line_tx = `PMT_SYM_R;
            default: nxt_line_tx = `PMT_SYM_I;
        endcase
        if (mode_ff != pmt_pkg::PMT_MII100)
            nxt_line_tx = pin_ff.txd;
    end

    // Transmit sequencer, used only in coded MII form
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I || mode_ff != pmt_pkg::PMT_MII100)
            tx_st_ff <= pmt_pkg::PMT_TX_IDLE;
        else
        begin
            case (tx_st_ff)
                pmt_pkg::PMT_TX_IDLE:
                    if (pin_ff.tx_en) tx_st_ff <= pmt_pkg::PMT_TX_K;
                pmt_pkg::PMT_TX_K: tx_st_ff <= pmt_pkg::PMT_TX_DATA;
                pmt_pkg::PMT_TX_DATA:
                    if (!pin_ff.tx_en) tx_st_ff <= pmt_pkg::PMT_TX_R;
                default: tx_st_ff <= pmt_pkg::PMT_TX_IDLE;
            endcase
        end
    end

    // Output registers
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            crs_ff <= 1'b0;
            col_ff <= 1'b0;
            rx_word_ff <= '0;
            rx_oe_b_ff <= 1'b1;
            line_tx_ff <= `PMT_SYM_I;
            line_tx_en_ff <= 1'b0;
        end
        else
        begin
            crs_ff <= rx_crs_lvl || tx_crs_lvl;
            col_ff <= col_lvl || sqe_ff;
            rx_word_ff <= nxt_rx_word;
            // RL11: receive outputs released one cycle after enable drops
            rx_oe_b_ff <= !pin_ff.rx_en;
            line_tx_ff <= nxt_line_tx;
            line_tx_en_ff <= pin_ff.tx_en || (tx_st_ff != pmt_pkg::PMT_TX_IDLE);
        end
    end

    // RL16: interface clock from a divider; 25 MHz is out of reach of this core clock
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            mii_clk_ff <= 1'b0;
            div_cnt_ff <= '0;
        end
        else if (div_cnt_ff >= half_cyc - CW'(1))
        begin
            mii_clk_ff <= !mii_clk_ff;
            div_cnt_ff <= '0;
        end
        else
            div_cnt_ff <= div_cnt_ff + CW'(1);
    end

    assign CRS_O = crs_ff;
    assign COL_O = col_ff;
    assign RX_DV_O = rx_word_ff.dv;
    assign RX_ER_O = rx_word_ff.er;
    assign RXD_O = rx_word_ff.data[3:0];
    assign RECEIVE_CODE_BIT_FOUR_O = rx_word_ff.data[4];
    assign RX_OE_B_O = rx_oe_b_ff;
    assign LINE_TX_O = line_tx_ff;
    assign LINE_TX_EN_O = line_tx_en_ff;
    assign MII_CLK_O = mii_clk_ff;

    property p_txcrs_100;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (fast && $rose(pin_ff.tx_en)) ##1 pin_ff.tx_en |-> ##1 crs_ff;
    endproperty
    a_txcrs_100: assert property (p_txcrs_100) else $error("carrier late after tx enable"); // RL5
    property p_txcrs_10;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (mode_ff == pmt_pkg::PMT_MII10 && $rose(pin_ff.tx_en)) |->
            ##[1:A_TXCRS10] (crs_ff || !pin_ff.tx_en);
    endproperty
    a_txcrs_10: assert property (p_txcrs_10) else $error("10M tx carrier late"); // RL12
    property p_col_100;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (fast && rx_busy_ff && pin_ff.tx_en)[*3] |-> col_ff;
    endproperty
    a_col_100: assert property (p_col_100) else $error("collision not raised"); // RL2
    property p_sqe_len;
        @(posedge CLK_I) disable iff (!RST_B_I)
        $rose(sqe_ff) |-> sqe_ff[*8] ##[1:4] !sqe_ff;
    endproperty
    a_sqe_len: assert property (p_sqe_len) else $error("test pulse length wrong"); // RL13
    property p_sqe_gap;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (!fast && $fell(tx_crs_lvl)) |-> !sqe_ff[*7] ##[1:12] sqe_ff;
    endproperty
    a_sqe_gap: assert property (p_sqe_gap) else $error("test pulse gap wrong"); // RL13
    property p_oe;
        @(posedge CLK_I) disable iff (!RST_B_I)
        $changed(pin_ff.rx_en) |=> (RX_OE_B_O != pin_ff.rx_en) || $changed(pin_ff.rx_en);
    endproperty
    a_oe: assert property (p_oe) else $error("output enable late"); // RL11
    property p_first_sym;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (mode_ff == pmt_pkg::PMT_MII100 && tx_st_ff == pmt_pkg::PMT_TX_IDLE && pin_ff.tx_en)
            |=> LINE_TX_O == `PMT_SYM_J ##1 LINE_TX_O == `PMT_SYM_K;
    endproperty
    a_first_sym: assert property (p_first_sym) else $error("start delimiter wrong"); // RL6
    property p_dv_after_crs;
        @(posedge CLK_I) disable iff (!RST_B_I)
        $rose(RX_DV_O) |-> CRS_O && $past(rx_crs_lvl, 2);
    endproperty
    a_dv_after_crs: assert property (p_dv_after_crs) else $error("data before carrier"); // RL3
    property p_crs_rx_100;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (coded && link_edge && sym == `PMT_SYM_J) ##1 rx_busy_ff |-> ##[1:2] crs_ff;
    endproperty
    a_crs_rx_100: assert property (p_crs_rx_100) else $error("rx carrier late"); // RL1
    property p_byp_tx;
        @(posedge CLK_I) disable iff (!RST_B_I)
        (mode_ff == pmt_pkg::PMT_BYP5B) |=> LINE_TX_O == $past(pin_ff.txd);
    endproperty
    a_byp_tx: assert property (p_byp_tx) else $error("bypass tx symbol wrong"); // RL7
endmodule : pmt_top

/* File: pmt_defines.svh */
`ifndef PMT_DEFINES_SVH
`define PMT_DEFINES_SVH

// Core clock and bit times
`define PMT_CLK_NS 100
`define PMT_BT100_NS 10
`define PMT_BT10_NS 100

// Cycle conversion: longest times round down, least round up, never under one
`define PMT_CYC_MAX(ns) ((((ns) / `PMT_CLK_NS) < 1) ? 1 : ((ns) / `PMT_CLK_NS))
`define PMT_CYC_MIN(ns) (((((ns) + `PMT_CLK_NS - 1) / `PMT_CLK_NS) < 1) ? 1 : \
    (((ns) + `PMT_CLK_NS - 1) / `PMT_CLK_NS))

// 100 Mb/s latencies, bit times except the two ns entries
`define PMT_CRS_ON_100_BT 11
`define PMT_CRS_OFF_100_BT 21
`define PMT_COL_ON_100_BT 11
`define PMT_COL_OFF_100_BT 21
`define PMT_DV_MAX_100_BT 8
`define PMT_BYP_RX_MAX_BT 9
`define PMT_TXCRS_ON_100_BT 8
`define PMT_TXCRS_OFF_100_BT 8
`define PMT_TXLAT_MAX_100_BT 8
`define PMT_BYP_TX_MAX_NS 7
`define PMT_MII_CLK_100_NS 40

// 10 Mb/s latencies
`define PMT_DV_TYP_10_BT 8
`define PMT_CRS_ON_10_BT 7
`define PMT_CRS_OFF_10_BT 3
`define PMT_COL_ON_10_BT 7
`define PMT_COL_OFF_10_BT 3
`define PMT_OE_MAX_NS 60
`define PMT_TXCRS_ON_10_BT 4
`define PMT_TXCRS_OFF_10_BT 16
`define PMT_SQE_DLY_NS 900
`define PMT_SQE_LEN_NS 1000
`define PMT_SER_CRS_NS 600
`define PMT_SER_DATA_NS 1200
`define PMT_MII_CLK_10_NS 400

// Control code groups
`define PMT_SYM_J 5'h18
`define PMT_SYM_K 5'h11
`define PMT_SYM_T 5'h0d
`define PMT_SYM_R 5'h07
`define PMT_SYM_I 5'h1f

`endif

/* File: pmt_pkg.sv */
package pmt_pkg;

    // Host-side interface forms
    typedef enum logic [2:0] {
        PMT_MII100,
        PMT_REP5B,
        PMT_BYP5B,
        PMT_MII10,
        PMT_SER10
    } pmt_mode_e;

    // Transmit symbol sequencer
    typedef enum logic [2:0] {
        PMT_TX_IDLE,
        PMT_TX_K,
        PMT_TX_DATA,
        PMT_TX_R
    } pmt_tx_e;

    // Pin bundle that crosses into the core clock
    typedef struct packed {
        logic act;
        logic lclk;
        logic [4:0] sym;
        logic tx_en;
        logic [4:0] txd;
        logic rx_en;
        logic align;
        logic coder;
        logic ser;
        logic spd100;
    } pmt_pin_s;

    // Receive word toward the controller
    typedef struct packed {
        logic dv;
        logic er;
        logic [4:0] data;
    } pmt_rx_s;

endpackage : pmt_pkg

/* File: pmt_delay.sv */
`timescale 1ns/100ps
// Level follower with separate rise and fall latencies in cycles
module pmt_delay #(
    parameter int CW = 5
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic [CW-1:0] on_cyc_i,
    input wire logic [CW-1:0] off_cyc_i,
    output logic lvl_o
);
    logic lvl_ff;
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] target;
    logic hit;

    // A request that flickers back restarts the wait
    assign target = req_i ? on_cyc_i : off_cyc_i;
    assign hit = (req_i != lvl_ff) && (cnt_ff == target - CW'(1));
    assign lvl_o = lvl_ff;

    // Count while request and level disagree
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            lvl_ff <= 1'b0;
            cnt_ff <= '0;
        end
        else if (req_i == lvl_ff || hit)
        begin
            lvl_ff <= req_i;
            cnt_ff <= '0;
        end
        else
        begin
            cnt_ff <= cnt_ff + CW'(1);
        end
    end
endmodule : pmt_delay

/* File: pmt_line_model.sv */
`timescale 1ns/100ps
// Far end of the line: one symbol per 800 ns link clock
module pmt_line_model (
    output logic act_o,
    output logic lclk_o,
    output logic [4:0] sym_o
);
    // Data code groups, nibble 0 first
    localparam logic [4:0] CODE [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    initial
    begin
        act_o = 1'b0;
        lclk_o = 1'b0;
        sym_o = 5'h00;
    end
    // Symbol set up half a period before the rising link edge
    task automatic put(input logic [4:0] s);
        sym_o = s;
        #400 lclk_o = 1'b1;
        #400 lclk_o = 1'b0;
    endtask : put
    // Clock stands still between frames; released symbol lines flip
    task automatic send_frame(input logic coded, input logic [3:0] nib, input int n);
        act_o = 1'b1;
        if (coded)
        begin
            put(5'h18);
            put(5'h11);
        end
        repeat (n) put(coded ? CODE[nib] : {1'b0, nib});
        if (coded)
        begin
            put(5'h0d);
            put(5'h07);
        end
        act_o = 1'b0;
        sym_o = ~sym_o;
    endtask : send_frame
endmodule : pmt_line_model

/* File: test_pmt_top.sv */
`timescale 1ns/100ps
module test_pmt_top;
    logic clk = 1'b0, rst_b = 1'b0, tx_en = 1'b0, rx_en = 1'b1;
    logic ser = 1'b0, spd = 1'b1, align = 1'b0, coder = 1'b0;
    logic [4:0] txd = 5'h00, sym, v;
    logic act, lclk, crs, col, dv, er, bit4, oe_b, txe, mclk, dv_q = 1'b0, txe_q = 1'b0;
    logic [3:0] rxd;
    logic [4:0] line_tx;
    logic [4:0] rxq[$], txq[$];
    int fail_count = 0, checked = 0, seed = 76617, n;
    always #50 clk = ~clk;
    pmt_top pmt_top_inst (.CLK_I(clk), .RST_B_I(rst_b), .LINE_ACT_I(act), .LINE_CLK_I(lclk),
        .LINE_SYM_I(sym), .TX_EN_I(tx_en), .TXD_I(txd), .RX_EN_I(rx_en),
        .ALIGN_BYPASS_SELECT_I(align), .CODER_BYPASS_SELECT_I(coder),
        .SERIAL_10M_SELECT_I(ser), .SPEED_100_I(spd), .CRS_O(crs), .COL_O(col),
        .RX_DV_O(dv), .RX_ER_O(er), .RXD_O(rxd), .RECEIVE_CODE_BIT_FOUR_O(bit4),
        .RX_OE_B_O(oe_b), .LINE_TX_O(line_tx), .LINE_TX_EN_O(txe), .MII_CLK_O(mclk));
    pmt_line_model pmt_line_model_inst (.act_o(act), .lclk_o(lclk), .sym_o(sym));
    task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic end_sim;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // Counts cycles until the chosen output reaches the level, capped
    task automatic wait_sig(input int sel, input logic lvl, input int lim, output int k);
        k = 0;
        while (k < lim && (sel == 0 ? crs : sel == 1 ? col : oe_b) !== lvl)
        begin
            @(negedge clk);
            k++;
        end
    endtask : wait_sig
    // Straps only take effect at reset release, so each form needs a reset
    // strap selection
    task automatic reset_mode(input logic [3:0] m);
        @(posedge clk);
        rst_b <= 1'b0;
        {ser, spd, align, coder} <= m;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : reset_mode
    task automatic tx_burst(input logic [4:0] first, input logic [4:0] d, input int len);
        txq.push_back(first);
        txd <= d;
        tx_en <= 1'b1;
        repeat (len) @(posedge clk);
        tx_en <= 1'b0;
    endtask : tx_burst
    // Results appear on rising valid edges, checked mid-cycle to dodge races
    always @(negedge clk)
    begin
        dv_q <= dv;
        txe_q <= txe;
        if (dv === 1'b1 && dv_q !== 1'b1)
            cmp({bit4, rxd}, rxq.size() > 0 ? rxq.pop_front() : 5'h1f);
        if (txe === 1'b1 && txe_q !== 1'b1)
            cmp(line_tx, txq.size() > 0 ? txq.pop_front() : 5'h00);
    end
    initial
    begin
        #500000;
        fail_count++;
        end_sim();
    end
    initial
    begin
        reset_mode(4'b0100);
        v = 5'($random(seed));
        txq.push_back(5'h18);
        txd <= v & 5'h0f;
        tx_en <= 1'b1;
        wait_sig(0, 1'b1, 6, n);
        cmp({4'h0, n < 6}, 5'h01);
        rxq.push_back(5'h05); // Second delimiter decodes to nibble 5
        fork
            pmt_line_model_inst.send_frame(1'b1, v[3:0], 4);
        join_none
        wait_sig(1, 1'b1, 20, n);
        cmp({4'h0, n < 20}, 5'h01);
        wait fork;
        @(posedge clk);
        tx_en <= 1'b0;
        wait_sig(0, 1'b0, 8, n);
        cmp({4'h0, n < 8}, 5'h01);
        reset_mode(4'b0000);
        v = 5'($random(seed)) & 5'h0f;
        fork
            tx_burst(v, v, 8);
        join_none
        // Pin sync and output register add three cycles to the 4 BT count
        wait_sig(0, 1'b1, 9, n);
        cmp({4'h0, n < 9}, 5'h01);
        wait fork;
        wait_sig(0, 1'b0, 21, n);
        cmp({4'h0, n < 21}, 5'h01);
        wait_sig(1, 1'b1, 20, n);
        cmp({4'h0, n >= 6 && n <= 16}, 5'h01);
        wait_sig(1, 1'b0, 20, n);
        cmp({4'h0, n >= 6 && n <= 16}, 5'h01);
        rxq.push_back(v);
        pmt_line_model_inst.send_frame(1'b0, v[3:0], 6);
        @(posedge clk);
        wait_sig(0, 1'b0, 8, n);
        cmp({4'h0, n < 8}, 5'h01);
        reset_mode(4'b1000);
        rxq.push_back(v & 5'h01);
        fork
            pmt_line_model_inst.send_frame(1'b0, v[3:0], 4);
        join_none
        wait_sig(0, 1'b1, 12, n);
        cmp({4'h0, n < 12}, 5'h01);
        wait fork;
        reset_mode(4'b0110);
        v = 5'($random(seed));
        tx_burst(v, v, 6);
        rx_en <= 1'b0;
        wait_sig(2, 1'b1, 5, n);
        cmp({4'h0, n < 5}, 5'h01);
        @(posedge clk);
        rx_en <= 1'b1;
        wait_sig(2, 1'b0, 5, n);
        cmp({4'h0, n < 5}, 5'h01);
        // Bypass hands the raw second delimiter up, fifth bit included
        rxq.push_back(5'h11);
        pmt_line_model_inst.send_frame(1'b1, v[3:0], 2);
        repeat (20) @(posedge clk);
        // Fast forms toggle the interface clock every core cycle
        @(negedge clk);
        v = {4'h0, mclk};
        @(negedge clk);
        cmp({4'h0, mclk}, v ^ 5'h01);
        cmp(5'(rxq.size() + txq.size()), 5'h00);
        end_sim();
    end
endmodule : test_pmt_top
